// ### pkg/priv_pkg.sv
/*
 Constants and types for the privilege and address-space unit.
 Assumes a 32-bit processor core around it with one clock.
*/
package priv_pkg;
	localparam int SEL_SUPER_BIT = 13;
	localparam int SEL_MASTER_BIT = 12;
	localparam logic [15:0] STATUS_RESET = 16'h2700;
	localparam logic [31:0] RESET_FETCH_ADDR = 32'h00000000;
	localparam logic [1:0] RESET_FETCH_WORDS = 2'h2;
	localparam logic [31:0] LONG_STEP = 32'h00000004;
	localparam logic [2:0] SPACE_USER_DATA = 3'h1;
	localparam logic [2:0] SPACE_USER_PROG = 3'h2;
	localparam logic [2:0] SPACE_SYS_DEFINED = 3'h3;
	localparam logic [2:0] SPACE_SUPER_DATA = 3'h5;
	localparam logic [2:0] SPACE_SUPER_PROG = 3'h6;
	localparam logic [2:0] SPACE_PROCESSOR = 3'h7;

	typedef enum logic [1:0] {
		ACC_DATA,
		ACC_PROG,
		ACC_PROCESSOR,
		ACC_ALTERNATE
	} access_kind_t;

	typedef enum logic [1:0] {
		RET_NONE,
		RET_SHORT,
		RET_FULL
	} return_kind_t;
endpackage

// ### pkg/space_if.sv
/*
 Carrier between the privilege unit and its space encoder.
 Assumes one clock domain; the signals are plain combinational values.
*/
`timescale 1ns/10ps
interface space_if;
	import priv_pkg::*;
	logic super_mode;
	access_kind_t kind;
	logic [2:0] alt_code;
	logic [2:0] code;
	modport ctrl (output super_mode, output kind, output alt_code,
		input code);
	modport enc (input super_mode, input kind, input alt_code,
		output code);
endinterface

// ### hdl/space_encoder.sv
/*
 Space code encoder: maps privilege and access kind to a space code.
 Assumes the caller presents a valid access kind every cycle.
*/
`timescale 1ns/10ps
module space_encoder
	import priv_pkg::*;
(
	space_if.enc sp
);
	always_comb begin
		case (sp.kind)
			ACC_DATA: begin
				sp.code = sp.super_mode ? SPACE_SUPER_DATA
					: SPACE_USER_DATA;
			end
			ACC_PROG: begin
				sp.code = sp.super_mode ? SPACE_SUPER_PROG
					: SPACE_USER_PROG;
			end
			ACC_PROCESSOR: begin
				sp.code = SPACE_PROCESSOR;
			end
			ACC_ALTERNATE: begin
				// Reserved codes 0 and 4 are remapped so they never reach pins.
				if (sp.alt_code == 3'h0 || sp.alt_code == 3'h4) begin
					sp.code = SPACE_SUPER_DATA;
				end else begin
					sp.code = sp.alt_code;
				end
			end
			default: begin
				sp.code = SPACE_SUPER_DATA;
			end
		endcase
	end
endmodule

// ### hdl/privilege_unit.sv
/*
 Privilege and address-space unit: status word select bits, stack
 pointer banking, space code generation, reset vector fetch and
 exception-return restore.
 Assumes the core executes instructions and presents bus requests.
*/
`timescale 1ns/10ps
module privilege_unit
	import priv_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// Status word update from the core
	input wire logic STATUS_WE,
	input wire logic [15:0] STATUS_IN,
	output logic [15:0] STATUS_WORD,
	// Instruction privilege check
	input wire logic INSTR_VALID,
	input wire logic INSTR_PRIVILEGED,
	output logic INSTR_ALLOWED,
	output logic PRIV_VIOLATION,
	// Stack alias register access
	input wire logic SP_WE,
	input wire logic [31:0] SP_IN,
	input wire logic USP_SELECT,
	output logic [31:0] SP_OUT,
	output logic [31:0] USER_STACK_POINTER,
	output logic [31:0] MASTER_STACK_POINTER,
	output logic [31:0] INTERRUPT_STACK_POINTER,
	// Bus cycle request from the core
	input wire logic BUS_REQ,
	input wire logic [31:0] BUS_ADDR,
	input wire logic [1:0] BUS_KIND,
	input wire logic [2:0] ALT_SPACE,
	input wire logic BUS_DONE,
	output logic [31:0] ADDR_OUT,
	output logic [2:0] SPACE_CODE_LINES,
	output logic CYCLE_VALID,
	// Reset vector fetch
	input wire logic [31:0] FETCH_DATA,
	output logic RESET_FETCH_BUSY,
	output logic [31:0] RESET_SP,
	output logic [31:0] RESET_PC,
	// Exception return
	input wire logic RET_REQ,
	input wire logic RET_FULL_FRAME,
	input wire logic [15:0] RET_STATUS,
	input wire logic [31:0] RET_PC,
	output logic [31:0] PC_OUT,
	output logic RESTORE_FULL_STATE
);
	typedef enum logic [1:0] {ST_FETCH_SP, ST_FETCH_PC, ST_RUN} boot_t;

	boot_t boot;
	logic [15:0] status;
	logic [31:0] user_stack_pointer;
	logic [31:0] master_stack_pointer;
	logic [31:0] interrupt_stack_pointer;
	logic [1:0] fetch_idx;
	logic super_mode;
	logic master;
	logic pending_ret;
	access_kind_t kind_req;
	logic [2:0] next_code;

	space_if sp ();

	space_encoder u_enc (
		.sp(sp)
	);

	assign super_mode = status[SEL_SUPER_BIT];
	assign master = status[SEL_MASTER_BIT];

	// Status word: reset, exception return, then plain writes.
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			status <= STATUS_RESET;
		end else if (RET_REQ && super_mode) begin
			status <= RET_STATUS;
		end else if (STATUS_WE && super_mode) begin
			status <= STATUS_IN;
		end
	end

	// Status writes at user level are dropped whole; PRIV_VIOLATION flags the privileged instruction.
	assign STATUS_WORD = status;

	assign INSTR_ALLOWED = super_mode || !INSTR_PRIVILEGED;
	assign PRIV_VIOLATION = INSTR_VALID && INSTR_PRIVILEGED &&
		!super_mode;

	// Stack pointer bank, selected by the two select bits.
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			user_stack_pointer <= 32'h00000000;
			master_stack_pointer <= 32'h00000000;
			interrupt_stack_pointer <= 32'h00000000;
		end else if (boot == ST_FETCH_SP && BUS_DONE) begin
			interrupt_stack_pointer <= FETCH_DATA;
		end else if (SP_WE) begin
			if (!super_mode || USP_SELECT) begin
				user_stack_pointer <= SP_IN;
			end else if (master) begin
				master_stack_pointer <= SP_IN;
			end else begin
				interrupt_stack_pointer <= SP_IN;
			end
		end
	end

	always_comb begin
		if (!super_mode || USP_SELECT) begin
			SP_OUT = user_stack_pointer;
		end else if (master) begin
			SP_OUT = master_stack_pointer;
		end else begin
			SP_OUT = interrupt_stack_pointer;
		end
	end

	assign USER_STACK_POINTER = user_stack_pointer;
	assign MASTER_STACK_POINTER = master_stack_pointer;
	assign INTERRUPT_STACK_POINTER = interrupt_stack_pointer;

	// Reset vector fetch: two long words, then normal running.
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			boot <= ST_FETCH_SP;
			fetch_idx <= 2'h0;
			RESET_SP <= 32'h00000000;
			RESET_PC <= 32'h00000000;
		end else begin
			case (boot)
				ST_FETCH_SP: begin
					if (BUS_DONE) begin
						RESET_SP <= FETCH_DATA;
						fetch_idx <= fetch_idx + 2'h1;
						boot <= ST_FETCH_PC;
					end
				end
				ST_FETCH_PC: begin
					if (BUS_DONE) begin
						RESET_PC <= FETCH_DATA;
						fetch_idx <= fetch_idx + 2'h1;
						boot <= ST_RUN;
					end
				end
				ST_RUN: begin
					boot <= ST_RUN;
				end
				default: begin
					boot <= ST_FETCH_SP;
				end
			endcase
		end
	end

	assign RESET_FETCH_BUSY = (boot != ST_RUN);

	// Alternate-space alternate_space_move are honoured only at supervisor level.
	always_comb begin
		kind_req = access_kind_t'(BUS_KIND);
		if (RESET_FETCH_BUSY) begin
			kind_req = ACC_PROG;
		end else if (kind_req == ACC_ALTERNATE && !super_mode) begin
			kind_req = ACC_DATA;
		end
	end

	assign sp.super_mode = super_mode;
	assign sp.kind = kind_req;
	assign sp.alt_code = ALT_SPACE;
	assign next_code = sp.code;

	// Address and space code are registered so they stay steady per cycle.
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ADDR_OUT <= RESET_FETCH_ADDR;
			SPACE_CODE_LINES <= SPACE_SUPER_PROG;
			CYCLE_VALID <= 1'b0;
		end else if (RESET_FETCH_BUSY) begin
			ADDR_OUT <= RESET_FETCH_ADDR + (LONG_STEP * {30'h0, fetch_idx});
			SPACE_CODE_LINES <= next_code;
			CYCLE_VALID <= !BUS_DONE;
		end else begin
			ADDR_OUT <= BUS_ADDR;
			SPACE_CODE_LINES <= next_code;
			CYCLE_VALID <= BUS_REQ;
		end
	end

	// Exception return: program counter and full-state restore strobe.
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			PC_OUT <= 32'h00000000;
			RESTORE_FULL_STATE <= 1'b0;
			pending_ret <= 1'b0;
		end else begin
			pending_ret <= RET_REQ && super_mode;
			RESTORE_FULL_STATE <= RET_REQ && super_mode &&
				RET_FULL_FRAME;
			if (boot == ST_FETCH_PC && BUS_DONE) begin
				PC_OUT <= FETCH_DATA;
			end else if (RET_REQ && super_mode) begin
				PC_OUT <= RET_PC;
			end
		end
	end

	AST_USER_REFUSED: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(INSTR_VALID && INSTR_PRIVILEGED && !super_mode) |->
		PRIV_VIOLATION)
		else $error("privileged instruction not refused at user level");
	AST_SUPER_ALLOWS: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		super_mode |-> INSTR_ALLOWED)
		else $error("instruction refused at supervisor level");
	AST_MASTER_SP: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(super_mode && master && !USP_SELECT) |-> SP_OUT == master_stack_pointer)
		else $error("master pointer not selected");
	AST_INT_SP: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(super_mode && !master && !USP_SELECT) |-> SP_OUT == interrupt_stack_pointer)
		else $error("interrupt pointer not selected");
	AST_USER_SP: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		!super_mode |-> SP_OUT == user_stack_pointer)
		else $error("user pointer not selected");
	AST_NO_RESERVED: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		SPACE_CODE_LINES != 3'h0 && SPACE_CODE_LINES != 3'h4)
		else $error("reserved space code driven");
	AST_SUPER_SPACE: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(super_mode && kind_req == ACC_DATA) |=>
		SPACE_CODE_LINES == SPACE_SUPER_DATA)
		else $error("supervisor data cycle has wrong space code");
	AST_CPU_SPACE: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(kind_req == ACC_PROCESSOR) |=>
		SPACE_CODE_LINES == SPACE_PROCESSOR)
		else $error("processor space cycle not coded seven");
	AST_BOOT_FETCH: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(boot == ST_FETCH_PC && !BUS_DONE) |=>
		ADDR_OUT == RESET_FETCH_ADDR + LONG_STEP &&
		SPACE_CODE_LINES == SPACE_SUPER_PROG)
		else $error("second reset fetch misplaced");
	AST_RET_RESTORE: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(RET_REQ && super_mode) |=>
		status == $past(RET_STATUS) && pending_ret)
		else $error("exception return did not restore status");
	AST_RESET_MODE: assert property (
		@(posedge CLOCK)
		$rose(RST_N) |-> super_mode && !master)
		else $error("reset mode not supervisor interrupt");
endmodule

// ### testbench/bus_memory.sv
/*
 Far-side model: memory that answers unit bus cycles after a wait.
 Assumes the unit holds its cycle steady until the answer is taken.
*/
`timescale 1ns/10ps
module bus_memory (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Cycle from the unit
	input wire logic valid,
	input wire logic [31:0] addr,
	input wire logic [2:0] space,
	input wire logic [1:0] wait_cycles,
	// Answer
	output logic done,
	output logic [31:0] data
);
	logic v;
	logic [31:0] a;
	logic [2:0] s;
	int cnt = 0;
	initial begin
		done = 1'b0;
		data = 32'h0;
	end
	// Data lines flip when not answering, so a stale word never matches.
	always @(posedge clock) begin
		v = valid;
		a = addr;
		s = space;
		#1;
		if (!rst_n || !v || done) begin
			done = 1'b0;
			cnt = 0;
			data = ~data;
		end else if (cnt < wait_cycles) begin
			cnt++;
			data = ~data;
		end else begin
			done = 1'b1;
			// Only supervisor program space holds vectors; processor
			// space and the reserved codes are never treated as memory.
			data = (s == 3'h6) ? (a ^ 32'h5a5a0f0f)
				: ~data;
		end
	end
endmodule

// ### testbench/privilege_and_space_code_unit_tb.sv
/*
 Self-checking bench for the privilege unit.
 Assumes the boot fetch of the unit and a bus answer after a random wait of 0 to 3 cycles.
*/
`timescale 1ns/10ps
module privilege_and_space_code_unit_tb import priv_pkg::*;;
	logic clock = 1'b0, rst_n = 1'b0, s_we = 1'b0, i_priv = 1'b1;
	logic sp_we = 1'b0, usp_sel = 1'b0, req = 1'b0, ret = 1'b0;
	logic full = 1'b0, done, allowed, viol, valid, busy, restore;
	logic [15:0] s_in = 16'h0, r_st = 16'h0, status;
	logic [31:0] sp_in = 32'h0, addr = 32'h0, r_pc = 32'h0, data, a_out;
	logic [31:0] sp_out, user_stack_pointer, master_stack_pointer, interrupt_stack_pointer, rsp, rpc, pc, r;
	logic [31:0] seed = 32'hfe12;
	logic [1:0] kind = 2'h0, wt = 2'h0;
	logic [2:0] alt = 3'h0, space, want;
	logic [2:0] user_space [4] = '{3'h1, 3'h2, 3'h7, 3'h1};
	int miscompares = 0, tests_run = 0;
	always #12.5 clock = ~clock;
	privilege_unit privilege_unit_i (.CLOCK(clock), .RST_N(rst_n),
		.STATUS_WE(s_we), .STATUS_IN(s_in), .STATUS_WORD(status),
		.INSTR_VALID(1'b1), .INSTR_PRIVILEGED(i_priv),
		.INSTR_ALLOWED(allowed), .PRIV_VIOLATION(viol), .SP_WE(sp_we),
		.SP_IN(sp_in), .USP_SELECT(usp_sel), .SP_OUT(sp_out),
		.USER_STACK_POINTER(user_stack_pointer), .MASTER_STACK_POINTER(master_stack_pointer),
		.INTERRUPT_STACK_POINTER(interrupt_stack_pointer), .BUS_REQ(req), .BUS_ADDR(addr),
		.BUS_KIND(kind), .ALT_SPACE(alt), .BUS_DONE(done), .ADDR_OUT(a_out),
		.SPACE_CODE_LINES(space), .CYCLE_VALID(valid), .FETCH_DATA(data),
		.RESET_FETCH_BUSY(busy), .RESET_SP(rsp), .RESET_PC(rpc),
		.RET_REQ(ret), .RET_FULL_FRAME(full), .RET_STATUS(r_st),
		.RET_PC(r_pc), .PC_OUT(pc), .RESTORE_FULL_STATE(restore));
	bus_memory bus_memory_i (.clock(clock), .rst_n(rst_n), .valid(valid),
		.addr(a_out), .space(space), .wait_cycles(wt), .done(done),
		.data(data));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(string n, logic [31:0] seen, logic [31:0] exp_v);
		tests_run++;
		if (seen !== exp_v) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, exp_v, seen);
		end
	endtask
	task automatic tick();
		@(posedge clock);
		#1;
	endtask
	task automatic boot();
		tick();
		chk("boot cycle", {valid, space}, {1'b1, SPACE_SUPER_PROG});
		chk("boot addr", a_out, RESET_FETCH_ADDR);
		for (int i = 0; i < 100 && busy !== 1'b0; i++)
			tick();
		chk("vector sp", rsp, 32'h5a5a0f0f);
		chk("vector pc", rpc, 32'h5a5a0f0b);
		chk("pc", pc, 32'h5a5a0f0b);
	endtask
	task automatic bus(logic [1:0] k, logic [2:0] a);
		tick();
		req = 1'b1;
		kind = k;
		alt = a;
		addr = rnd();
		tick();
		req = 1'b0;
		chk("address", a_out, addr);
		chk("cycle valid", valid, 1'b1);
	endtask
	task automatic wr(logic st, logic sel, logic [15:0] v);
		tick();
		s_we = st;
		s_in = v;
		sp_we = !st;
		usp_sel = sel;
		sp_in = rnd();
		tick();
		s_we = 1'b0;
		sp_we = 1'b0;
	endtask
	task automatic eret(logic f, logic [15:0] st);
		tick();
		ret = 1'b1;
		full = f;
		r_st = st;
		r_pc = rnd();
		tick();
		ret = 1'b0;
	endtask
	task automatic stop_test();
		$display("Counts: %0d checks, %0d mismatches", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clock);
		miscompares++;
		stop_test();
	end
	initial begin
		r = rnd();
		wt = r[1:0];
		repeat (6) @(posedge clock);
		#1;
		chk("select bits", status[13:12], 2'b10);
		rst_n = 1'b1;
		boot();
		$display("test boot done");
		for (int k = 0; k < 3; k++) begin
			bus(k[1:0], 3'h0);
			chk("super space", space, k + 5);
		end
		// Every alternate code, reserved ones included.
		for (int a = 0; a < 8; a++) begin
			want = (a == 0 || a == 4) ? 3'h5 : a[2:0];
			bus(2'h3, a[2:0]);
			chk("alt space", space, want);
		end
		$display("test space done");
		wr(1'b1, 1'b0, 16'h3000);
		wr(1'b0, 1'b0, 16'h0);
		chk("master", master_stack_pointer, sp_in);
		chk("sp out", sp_out, sp_in);
		wr(1'b1, 1'b0, 16'h2000);
		wr(1'b0, 1'b0, 16'h0);
		chk("interrupt", interrupt_stack_pointer, sp_in);
		wr(1'b0, 1'b1, 16'h0);
		r = sp_in;
		chk("user", user_stack_pointer, r);
		chk("priv", {viol, allowed}, 2'b01);
		$display("test stack done");
		eret(1'b1, 16'h2000);
		chk("full restore", restore, 1'b1);
		eret(1'b0, 16'h0000);
		chk("short frame", restore, 1'b0);
		chk("status", status, 16'h0);
		chk("pc", pc, r_pc);
		chk("user sp", sp_out, r);
		chk("priv", {viol, allowed}, 2'b10);
		for (int k = 0; k < 4; k++) begin
			bus(k[1:0], 3'h6);
			chk("user space", space, user_space[k]);
		end
		wr(1'b1, 1'b0, 16'h2000);
		chk("status", status, 16'h0);
		$display("test user done");
		rst_n = 1'b0;
		#1;
		chk("select bits", status[13:12], 2'b10);
		tick();
		rst_n = 1'b1;
		boot();
		$display("test reset done");
		stop_test();
	end
endmodule
